// ---- asp_audio_port.v ----
// Stereo audio serial port with master/slave clocking, four formats and power-down.
//
// Local design decision: the plain strobed port.
`timescale 1ns/100ps
`include "asp_map.vh"

module asp_audio_port (
   input  wire        core_clk_in,
   input  wire        rstn_in,
   input  wire [7:0]  reg_addr_in,
   input  wire [7:0]  reg_wdata_in,
   input  wire        reg_wr_in,
   input  wire        reg_rd_in,
   output reg  [7:0]  reg_rdata_out,
   input  wire        mclk_in,
   input  wire        spdif_lock_in,
   input  wire        bitclk_in,
   output reg         bitclk_out,
   output reg         bitclk_oe_out,
   input  wire        frmclk_in,
   output reg         frmclk_out,
   output reg         frmclk_oe_out,
   input  wire        sdata_in,
   output reg         sdata_out,
   output reg  [23:0] tx_data_out,
   output reg         tx_left_out,
   output reg         tx_strobe_out,
   input  wire [23:0] rx_left_in,
   input  wire [23:0] rx_right_in,
   input  wire        rx_valid_in
);

   reg  [7:0]  in_ctl_q;
   reg  [7:0]  out_ctl_q;
   reg  [7:0]  misc_q;
   reg  [7:0]  rdata_d;
   reg         bclk_q;
   reg         bclk_d;
   reg         mclk_prev_q;
   reg         div_q;
   reg  [8:0]  gcnt_q;
   reg  [8:0]  gcnt_d;
   reg         frm_q;
   reg         frm_d;
   reg         in_eff_prev_q;
   reg         in_ref_prev_q;
   reg  [8:0]  in_pos_q;
   reg  [23:0] in_sh_q;
   reg         in_arm_q;
   reg         out_eff_prev_q;
   reg         out_ref_prev_q;
   reg  [8:0]  out_pos_q;
   reg  [8:0]  out_half_q;
   reg         out_arm_q;
   reg  [23:0] rxl_q;
   reg  [23:0] rxr_q;
   reg         out_bit;

   // Word length decode shared by both directions.
   // Both length codes with the upper bit set give the longest word, so no
   // code is left without a meaning and a stray write cannot stall a frame.
   function [5:0] wl_of;
      input [1:0] code;
      begin
         case (code)
            2'h0:    wl_of = `ASP_WL_16;
            2'h1:    wl_of = `ASP_WL_20;
            default: wl_of = `ASP_WL_24;
         endcase
      end
   endfunction

   // Control fields.
   // The role, the clock-hold bit and the launch-side settings live in the
   // output control register; the capture side has its own format, length,
   // invert and polarity bits in the input control register.
   // Changing a format while frames run may corrupt the word in flight; the
   // port only settles again at the next left-channel frame start.
   wire [1:0] in_fmt    = in_ctl_q[`ASP_FMT_LSB+1:`ASP_FMT_LSB];
   wire [1:0] out_fmt   = out_ctl_q[`ASP_FMT_LSB+1:`ASP_FMT_LSB];
   wire [5:0] in_wl     = wl_of(in_ctl_q[`ASP_WL_LSB+1:`ASP_WL_LSB]);
   wire [5:0] out_wl    = wl_of(out_ctl_q[`ASP_WL_LSB+1:`ASP_WL_LSB]);
   wire       in_inv    = in_ctl_q[`ASP_BCP_BIT];
   wire       out_inv   = out_ctl_q[`ASP_BCP_BIT];
   wire       in_pol    = in_ctl_q[`ASP_LRP_BIT];
   wire       out_pol   = out_ctl_q[`ASP_LRP_BIT];
   wire       master    = out_ctl_q[`ASP_MS_BIT];
   wire       hold      = out_ctl_q[`ASP_HOLD_BIT];
   wire       ratio128  = misc_q[`ASP_RATIO_BIT];
   wire       pd        = misc_q[`ASP_PD_BIT];
   wire       in_dsp    = (in_fmt == `ASP_FMT_DSP);
   wire       out_dsp   = (out_fmt == `ASP_FMT_DSP);

   // Register writes; the power-down bit comes up set.
   // The port therefore stays quiet after reset until software clears the
   // power-down bit, whatever the pins do meanwhile.
   // Writes to unmapped offsets and to the read-only status byte are ignored.
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         in_ctl_q  <= `ASP_CTL_RESET;
         out_ctl_q <= `ASP_CTL_RESET;
         misc_q    <= `ASP_MISC_RESET;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `ASP_IN_CTL_ADDR:  in_ctl_q  <= reg_wdata_in;
            `ASP_OUT_CTL_ADDR: out_ctl_q <= reg_wdata_in;
            `ASP_MISC_ADDR:    misc_q    <= reg_wdata_in;
            default:           misc_q    <= misc_q;
         endcase
      end
   end

   // Read mux; data stand only in the cycle after the strobe.
   // A read costs one cycle and never stalls the master; the data fall back
   // to zero afterwards so that a stale byte is never taken for a fresh one.
   // The status byte shows the lock input, both arm flags and the pin enable.
   always @* begin
      rdata_d = 8'h00;
      if (reg_rd_in) begin
         case (reg_addr_in)
            `ASP_IN_CTL_ADDR:  rdata_d = in_ctl_q;
            `ASP_OUT_CTL_ADDR: rdata_d = out_ctl_q;
            `ASP_MISC_ADDR:    rdata_d = misc_q;
            `ASP_STAT_ADDR:    rdata_d = {4'h0, spdif_lock_in, out_arm_q, in_arm_q, bitclk_oe_out};
            default:           rdata_d = 8'h00;
         endcase
      end
   end

   // Read data register; the output pin comes straight from this flop.
   // Keeping the mux in front of it holds the answer to exactly one cycle.
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_rdata_out <= 8'h00;
      end else begin
         reg_rdata_out <= rdata_d;
      end
   end

   // Clock generation runs only in master mode, powered up, with a source or hold.
   // The master clock is sampled on the core clock, so it must run below half
   // the core rate; each sampled rising edge is one step of the divider.
   // When the received stream is lost and the hold bit is clear, both clocks
   // park low and their pin enables drop, so the partner sees no half bits.
   // The frame counter is preloaded so that the first fall after a start
   // opens a frame at once instead of after a full frame of idle bits.
   wire run     = master & ~pd & (spdif_lock_in | hold);
   wire mrise   = mclk_in & ~mclk_prev_q;
   wire [8:0] frame_len = out_dsp ? (ratio128 ? `ASP_FRAME_DSP128 : `ASP_FRAME_DSP256) : `ASP_FRAME_JUST;
   wire gfall   = bclk_q & ~bclk_d;

   // Bit clock divider; the master clock is the recovered stream clock.
   // In the DSP format the bit clock is the sampled master clock itself, so
   // the length of a frame, not the divider, sets the sample rate there.
   // The divide-by-four path toggles on every second sampled rising edge.
   always @* begin
      if (!run) begin
         bclk_d = 1'b0;
      end else if (out_dsp) begin
         bclk_d = mclk_in;
      end else if (ratio128) begin
         bclk_d = mrise ? ~bclk_q : bclk_q;
      end else begin
         bclk_d = (mrise & div_q) ? ~bclk_q : bclk_q;
      end
   end

   // Frame clock from the count of generated bit clock falls.
   // While the clocks run, the frame clock changes only together with a bit clock fall, so the
   // launch side sees the change on the same edge that moves its data.
   // In the DSP formats the sync is one bit clock wide at the frame start;
   // otherwise the two halves are equal and take polarity and format into account.
   always @* begin
      gcnt_d = gcnt_q;
      frm_d  = frm_q;
      if (!run) begin
         gcnt_d = frame_len - 9'h001;
         frm_d  = 1'b0;
      end else if (gfall) begin
         gcnt_d = (gcnt_q >= frame_len - 9'h001) ? 9'h000 : gcnt_q + 9'h001;
         if (out_dsp) begin
            frm_d = (gcnt_d == 9'h000);
         end else begin
            frm_d = (gcnt_d < `ASP_HALF_JUST) ^ out_pol ^ (out_fmt == `ASP_FMT_I2S);
         end
      end
   end

   // Clock state and the pin copies; the pins take the next value so that
   // they stand in step with the internal copy used by the port logic.
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         mclk_prev_q   <= 1'b0;
         div_q         <= 1'b0;
         bclk_q        <= 1'b0;
         gcnt_q        <= 9'h000;
         frm_q         <= 1'b0;
         bitclk_out    <= 1'b0;
         frmclk_out    <= 1'b0;
         bitclk_oe_out <= 1'b0;
         frmclk_oe_out <= 1'b0;
      end else begin
         mclk_prev_q   <= mclk_in;
         div_q         <= run ? (div_q ^ mrise) : 1'b0;
         bclk_q        <= bclk_d;
         gcnt_q        <= gcnt_d;
         frm_q         <= frm_d;
         bitclk_out    <= bclk_d;
         frmclk_out    <= frm_d;
         bitclk_oe_out <= run;
         frmclk_oe_out <= run;
      end
   end

   // Bit and frame clock seen by the port logic.
   // In slave mode the pins are taken as synchronous to the core clock; the
   // partner must hold each bit clock phase for at least one core cycle or
   // an edge is lost.
   wire bclk_src = master ? bclk_q : bitclk_in;
   wire lr_src   = master ? frm_q : frmclk_in;

   // Capture direction: serial input towards the transmitter.
   // Bits are shifted in on every effective rise and counted from the last
   // frame clock change (the sync rise in DSP); the word is handed on once the last bit of a word arrives.
   // Right-justified framing cannot know where a word starts, so there the
   // word is handed on at the rise that sees the frame clock change.
   // Captured words are left aligned in the 24-bit output with zeros below.
   wire       in_eff    = bclk_src ^ in_inv;
   wire       in_rise   = in_eff & ~in_eff_prev_q;
   wire       in_ref    = in_dsp ? lr_src : (lr_src ^ in_pol ^ (in_fmt == `ASP_FMT_I2S));
   wire       in_start  = in_dsp ? (in_ref & ~in_ref_prev_q) : (in_ref ^ in_ref_prev_q);
   wire [8:0] in_pos_d  = in_start ? 9'h000 : ((in_pos_q == 9'h1ff) ? in_pos_q : in_pos_q + 9'h001);
   wire       in_off    = (in_fmt == `ASP_FMT_I2S) | (in_dsp & ~in_pol);
   wire [8:0] in_idx    = in_pos_d - {8'h00, in_off};
   wire [8:0] in_wl9    = {3'h0, in_wl};
   wire [23:0] in_sh_d  = {in_sh_q[22:0], sdata_in};
   wire [4:0] in_sft    = 5'h18 - in_wl[4:0];
   wire       in_rj     = (in_fmt == `ASP_FMT_RJ);
   wire       in_done_w = in_dsp ? ((in_idx == in_wl9 - 9'h001) | (in_idx == {in_wl9[7:0], 1'b0} - 9'h001))
                                 : (in_idx == in_wl9 - 9'h001);
   wire       in_done   = in_rj ? (in_start & in_arm_q) : (in_done_w & in_arm_q);
   wire [23:0] in_word  = in_rj ? (in_sh_q << in_sft) : (in_sh_d << in_sft);
   wire       in_left   = in_rj ? in_ref_prev_q : (in_dsp ? (in_idx < in_wl9) : in_ref);
   wire       in_frame  = in_start & in_ref;

   // Capture registers; power-down clears the arm flag so that capture only
   // resumes at the next complete left-channel frame.
   // The word strobe is a single-cycle pulse beside the held word and side.
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         in_eff_prev_q <= 1'b0;
         in_ref_prev_q <= 1'b0;
         in_pos_q      <= 9'h000;
         in_sh_q       <= 24'h000000;
         in_arm_q      <= 1'b0;
         tx_data_out   <= 24'h000000;
         tx_left_out   <= 1'b0;
         tx_strobe_out <= 1'b0;
      end else begin
         in_eff_prev_q <= in_eff;
         tx_strobe_out <= 1'b0;
         if (pd) begin
            in_arm_q <= 1'b0;
            in_pos_q <= 9'h000;
         end else if (in_rise) begin
            in_ref_prev_q <= in_ref;
            in_pos_q      <= in_pos_d;
            in_sh_q       <= in_sh_d;
            if (in_frame) begin
               in_arm_q <= 1'b1;
            end
            if (in_done) begin
               tx_data_out   <= in_word;
               tx_left_out   <= in_left;
               tx_strobe_out <= 1'b1;
            end
         end
      end
   end

   // Launch direction: received samples onto the serial output.
   // Data move on the effective fall; the receiver samples on the next rise.
   // Right-justified output counts back from the end of the half, using the
   // length of the previous half, so the first half after arming may be
   // placed by a stale length; later halves are exact.
   // The samples are latched on the valid pulse and used from the next launch.
   wire       out_eff   = bclk_src ^ out_inv;
   wire       out_fall  = ~out_eff & out_eff_prev_q;
   wire       out_ref   = out_dsp ? lr_src : (lr_src ^ out_pol ^ (out_fmt == `ASP_FMT_I2S));
   wire       out_start = out_dsp ? (out_ref & ~out_ref_prev_q) : (out_ref ^ out_ref_prev_q);
   wire [8:0] out_pos_d = out_start ? 9'h000 : ((out_pos_q == 9'h1ff) ? out_pos_q : out_pos_q + 9'h001);
   wire       out_arm_d = out_arm_q | (out_start & out_ref);
   wire       out_off   = (out_fmt == `ASP_FMT_I2S) | (out_dsp & ~out_pol);
   wire [8:0] out_wl9   = {3'h0, out_wl};
   wire [8:0] out_half  = out_start ? out_pos_q + 9'h001 : out_half_q;
   wire [8:0] out_idx   = (out_fmt == `ASP_FMT_RJ) ? (out_pos_d + out_wl9 - out_half)
                                                   : (out_pos_d - {8'h00, out_off});
   wire [8:0] out_lim   = out_dsp ? {out_wl9[7:0], 1'b0} : out_wl9;
   wire       out_left  = out_dsp ? (out_idx < out_wl9) : out_ref;
   wire [8:0] out_k9    = (out_dsp & ~out_left) ? (out_idx - out_wl9) : out_idx;
   wire [4:0] out_k     = out_k9[4:0];
   wire [23:0] out_word = out_left ? rxl_q : rxr_q;

   // Selected bit, MSB first, low outside the data window.
   // Driving zero beyond the word keeps padding bits quiet in wide halves.
   always @* begin
      out_bit = 1'b0;
      if (out_arm_d && (out_idx < out_lim)) begin
         out_bit = out_word[5'h17 - out_k];
      end
   end

   // Launch registers; the data pin is always driven, and held low while
   // the port is powered down.
   // Launch resumes at the next left-channel frame start after power-up.
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         out_eff_prev_q <= 1'b0;
         out_ref_prev_q <= 1'b0;
         out_pos_q      <= 9'h000;
         out_half_q     <= 9'h000;
         out_arm_q      <= 1'b0;
         rxl_q          <= 24'h000000;
         rxr_q          <= 24'h000000;
         sdata_out      <= 1'b0;
      end else begin
         out_eff_prev_q <= out_eff;
         if (rx_valid_in) begin
            rxl_q <= rx_left_in;
            rxr_q <= rx_right_in;
         end
         if (pd) begin
            out_arm_q <= 1'b0;
            out_pos_q <= 9'h000;
            sdata_out <= 1'b0;
         end else if (out_fall) begin
            out_ref_prev_q <= out_ref;
            out_pos_q      <= out_pos_d;
            out_half_q     <= out_half;
            out_arm_q      <= out_arm_d;
            sdata_out      <= out_bit;
         end
      end
   end

endmodule

// ---- asp_map.vh ----
// Register map, field positions, reset values and framing constants of the audio serial port.
`ifndef ASP_MAP_VH
`define ASP_MAP_VH

// Register byte offsets.
`define ASP_IN_CTL_ADDR   8'h1b
`define ASP_OUT_CTL_ADDR  8'h1c
`define ASP_MISC_ADDR     8'h1e
`define ASP_STAT_ADDR     8'h1f

// Per-direction control fields; role and hold are taken from the output control only.
`define ASP_FMT_LSB       0
`define ASP_WL_LSB        2
`define ASP_BCP_BIT       4
`define ASP_LRP_BIT       5
`define ASP_MS_BIT        6
`define ASP_HOLD_BIT      7

// Miscellaneous control fields.
`define ASP_RATIO_BIT     0
`define ASP_PD_BIT        5

// Reset values.
`define ASP_CTL_RESET     8'h06
`define ASP_MISC_RESET    8'h20

// Format codes.
`define ASP_FMT_RJ        2'h0
`define ASP_FMT_LJ        2'h1
`define ASP_FMT_I2S       2'h2
`define ASP_FMT_DSP       2'h3

// Word lengths.
`define ASP_WL_16         6'h10
`define ASP_WL_20         6'h14
`define ASP_WL_24         6'h18

// Bit clocks per frame, and per half frame, when generating clocks.
`define ASP_HALF_JUST     9'h020
`define ASP_FRAME_JUST    9'h040
`define ASP_FRAME_DSP128  9'h080
`define ASP_FRAME_DSP256  9'h100

`endif

// ---- asp_ptnr_model.sv ----
// Partner model: an audio processor driving slave clocks in 16-bit left-justified framing.
`timescale 1ns/100ps
module asp_ptnr_model (
   input  wire        clk_in,
   input  wire        run_in,
   input  wire        sdat_in,
   output wire        bclk_out,
   output wire        fclk_out,
   output wire        sdat_out,
   output reg  [15:0] got_left_out
);
   localparam [15:0] L_WORD = 16'ha5c3;
   localparam [15:0] R_WORD = 16'h3c5a;
   reg  [7:0]  ph_q = 8'h00;
   reg  [15:0] sh_q = 16'h0000;
   wire [15:0] word = ph_q[7] ? R_WORD : L_WORD;
   // Eight core cycles a bit, sixteen bits a half; clocks stand low while idle.
   assign bclk_out = run_in & ph_q[2];
   assign fclk_out = run_in & ~ph_q[7];
   // The MSB leaves on the fall where the frame clock changes; an idle line stays low.
   assign sdat_out = run_in ? word[~ph_q[6:3]] : ph_q[0];
   // Sample the device one cycle after each rise and keep the left word at mid-frame.
   always @(posedge clk_in) begin
      ph_q <= run_in ? ph_q + 8'h01 : 8'h00;
      if (ph_q[2:0] == 3'h4)
         sh_q <= {sh_q[14:0], sdat_in};
      if (ph_q == 8'h80)
         got_left_out <= sh_q;
   end
endmodule

// ---- asp_audio_port_assertions.sv ----
// Checker of the audio serial port, bound to its ports.
`timescale 1ns/100ps
`include "asp_map.vh"
module asp_audio_port_chk (
   input wire       core_clk_in,
   input wire       rstn_in,
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire       reg_wr_in,
   input wire       reg_rd_in,
   input wire [7:0] reg_rdata_out,
   input wire       spdif_lock_in,
   input wire       bitclk_in,
   input wire       bitclk_oe_out,
   input wire       frmclk_oe_out,
   input wire       sdata_out,
   input wire       tx_strobe_out
);
   reg ms_q;
   reg hold_q;
   reg pd_q;
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   // Shadow of role, hold and power-down bits as software writes them.
   always @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ms_q <= 1'b0;
         hold_q <= 1'b0;
         pd_q <= 1'b1;
      end else if (reg_wr_in && reg_addr_in == `ASP_OUT_CTL_ADDR) begin
         ms_q <= reg_wdata_in[6];
         hold_q <= reg_wdata_in[7];
      end else if (reg_wr_in && reg_addr_in == `ASP_MISC_ADDR) begin
         pd_q <= reg_wdata_in[5];
      end
   end
   a_rdata_idle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
      else $error("read data outside its cycle");
   a_slave_no_drive: assert property ((!ms_q)[*4] |-> !bitclk_oe_out && !frmclk_oe_out)
      else $error("clock pins driven in slave mode");
   a_oe_needs_master: assert property (bitclk_oe_out |-> $past(ms_q) && $past(!pd_q))
      else $error("clock driven without master role");
   a_oe_pair: assert property (bitclk_oe_out == frmclk_oe_out)
      else $error("clock enables differ");
   a_stop_no_lock: assert property ((!spdif_lock_in && !hold_q)[*6] |-> !bitclk_oe_out)
      else $error("clocks kept without source");
   a_pd_out_low: assert property (pd_q[*4] |-> sdata_out == 1'b0)
      else $error("data out not low in power down");
   a_pd_no_capture: assert property (pd_q[*4] |-> !tx_strobe_out)
      else $error("capture in power down");
   a_strobe_pulse: assert property (tx_strobe_out |=> !tx_strobe_out)
      else $error("word strobe longer than one cycle");
   a_dout_on_fall: assert property (!ms_q && !pd_q && $past(!pd_q, 4) && $changed(sdata_out)
      |-> !$past(bitclk_in) || !$past(bitclk_in, 2) || !$past(bitclk_in, 3))
      else $error("data out changed away from a fall");
endmodule
bind asp_audio_port asp_audio_port_chk u_chk (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
   .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
   .reg_rdata_out(reg_rdata_out), .spdif_lock_in(spdif_lock_in), .bitclk_in(bitclk_in),
   .bitclk_oe_out(bitclk_oe_out), .frmclk_oe_out(frmclk_oe_out), .sdata_out(sdata_out),
   .tx_strobe_out(tx_strobe_out));

// ---- testbench.sv ----
// Self-checking testbench of the audio serial port.
`timescale 1ns/100ps
`include "asp_map.vh"
module testbench;
   reg         clk = 1'b0;
   reg         rstn = 1'b0;
   reg  [7:0]  addr = 8'h00;
   reg  [7:0]  wdata = 8'h00;
   reg         wr_s = 1'b0;
   reg         rd_s = 1'b0;
   reg         lock = 1'b0;
   reg         run = 1'b0;
   reg         rxv = 1'b0;
   reg  [1:0]  mcnt = 2'h0;
   wire [7:0]  rdata;
   wire        bco, bcoe, fco, fcoe, pbc, pfc, pdat, dout, txl, txs;
   wire [23:0] txd;
   wire [15:0] got;
   integer     bad_count = 0;
   integer     n_compared = 0;
   integer     i, k;
   asp_audio_port u_dut (.core_clk_in(clk), .rstn_in(rstn), .reg_addr_in(addr), .reg_wdata_in(wdata),
      .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata), .mclk_in(mcnt[1]), .spdif_lock_in(lock),
      .bitclk_in(bcoe ? bco : pbc), .bitclk_out(bco), .bitclk_oe_out(bcoe), .frmclk_in(fcoe ? fco : pfc),
      .frmclk_out(fco), .frmclk_oe_out(fcoe), .sdata_in(pdat), .sdata_out(dout), .tx_data_out(txd),
      .tx_left_out(txl), .tx_strobe_out(txs), .rx_left_in(24'h9a5b00), .rx_right_in(24'h1e2d00),
      .rx_valid_in(rxv));
   asp_ptnr_model u_ptnr (.clk_in(clk), .run_in(run), .sdat_in(dout), .bclk_out(pbc), .fclk_out(pfc),
      .sdat_out(pdat), .got_left_out(got));
   // Core clock and a master clock at a quarter of its rate.
   initial forever #5 clk = ~clk;
   always @(posedge clk) mcnt <= mcnt + 2'h1;
   task tally_and_finish;
   begin
      $display("compared %0d mismatched %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   task chk(input [63:0] nm, input [23:0] seen, input [23:0] exp_v);
   begin
      n_compared = n_compared + 1;
      if (seen !== exp_v) begin
         bad_count = bad_count + 1;
         $display("wrong value %0s expected %h seen %h", nm, exp_v, seen);
      end
   end
   endtask
   task expire(input integer n);
   begin
      if (n >= 3000) begin
         bad_count = bad_count + 1;
         tally_and_finish;
      end
   end
   endtask
   task reg_wr(input [7:0] a, input [7:0] d);
   begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk);
      wr_s <= 1'b0;
   end
   endtask
   task reg_rd(input [7:0] a, input [7:0] e);
   begin
      @(posedge clk);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk);
      rd_s <= 1'b0;
      @(negedge clk);
      chk("reg", {16'h0000, rdata}, {16'h0000, e});
   end
   endtask
   task wait_word(input lft, input [23:0] e);
   begin
      k = 0;
      while (!(txs === 1'b1 && txl === lft) && k < 3000) begin
         @(negedge clk);
         k = k + 1;
      end
      expire(k);
      chk("tx word", txd, e);
      @(negedge clk);
   end
   endtask
   task period(input sel, input [23:0] e);
      integer t, r, n;
      reg p, c;
   begin
      t = 0;
      r = 0;
      n = 0;
      p = 1'b1;
      while (r < 2 && n < 3000) begin
         @(negedge clk);
         n = n + 1;
         c = sel ? fco : bco;
         if (r == 1)
            t = t + 1;
         if (c === 1'b1 && !p)
            r = r + 1;
         p = c;
      end
      expire(n);
      chk("clk per", t, e);
   end
   endtask
   // Main sequence of tests.
   initial begin
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      reg_rd(`ASP_IN_CTL_ADDR, 8'h06);
      reg_rd(`ASP_OUT_CTL_ADDR, 8'h06);
      reg_rd(`ASP_MISC_ADDR, 8'h20);
      reg_rd(8'h00, 8'h00);
      $display("test reset values done");
      reg_wr(`ASP_OUT_CTL_ADDR, 8'h01);
      reg_wr(`ASP_IN_CTL_ADDR, 8'h01);
      reg_rd(`ASP_OUT_CTL_ADDR, 8'h01);
      reg_wr(`ASP_MISC_ADDR, 8'h00);
      @(posedge clk) rxv <= 1'b1;
      @(posedge clk) rxv <= 1'b0;
      run <= 1'b1;
      for (i = 0; i < 3; i = i + 1) begin
         wait_word(1'b1, 24'ha5c300);
         wait_word(1'b0, 24'h3c5a00);
      end
      chk("dout", {8'h00, got}, 24'h009a5b);
      $display("test slave left-justified done");
      reg_wr(`ASP_MISC_ADDR, 8'h20);
      k = 0;
      for (i = 0; i < 600; i = i + 1)
         @(negedge clk) k = k + (txs === 1'b1 ? 1 : 0);
      chk("strobes", k, 24'h000000);
      run <= 1'b0;
      $display("test power down done");
      lock <= 1'b1;
      reg_wr(`ASP_OUT_CTL_ADDR, 8'h41);
      reg_wr(`ASP_MISC_ADDR, 8'h00);
      period(1'b0, 24'd16);
      chk("oe", bcoe, 24'h000001);
      reg_wr(`ASP_MISC_ADDR, 8'h01);
      period(1'b0, 24'd8);
      reg_wr(`ASP_OUT_CTL_ADDR, 8'h43);
      period(1'b0, 24'd4);
      period(1'b1, 24'd512);
      reg_wr(`ASP_OUT_CTL_ADDR, 8'h41);
      lock <= 1'b0;
      repeat (20) @(negedge clk);
      chk("oe", bcoe, 24'h000000);
      reg_wr(`ASP_OUT_CTL_ADDR, 8'hc1);
      period(1'b0, 24'd8);
      period(1'b1, 24'd512);
      chk("oe", fcoe, 24'h000001);
      reg_rd(`ASP_STAT_ADDR, 8'h07);
      $display("test master clocks done");
      tally_and_finish;
   end
endmodule
